// file: uart_data_status_regs.sv
// Purpose: serial port data and status registers with frame engines
// Assumes: Avalon-MM slave, byte address, one word per register
// Notes: fixed bit rate; transmit words pass a two-entry buffer
// How it works
// - written byte is shifted out serially
// - one address: write transmit, read receive
// - received byte lands in receive holding
// - available flag set on byte, read clears
// - parity error flag set, data read clears
// - overrun when new byte meets unread byte
// - read clears overrun only if none available
// - framing error on missing stop, read clears
// - break flag on all-zero frame, read clears
// - holding-empty resets one, write clears it
// - transmitter-empty one when idle, zero sending
// - status bit zero shows sampled clear-to-send
// - overrun keeps the older byte
// - holding-empty sets after first bit sent
// - data read clears new-frame and multiproc bit
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module uart_data_status_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // avalon-mm slave
  input wire logic [13:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // serial link
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  input wire logic cts_n_i
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] readdata_ff;
  logic wait_ff;
  logic [3:0] ctrl_ff;
  logic cts_ff;
  logic [7:0] rx_hold_ff;
  logic avail_ff, par_err_ff, oe_ff, frm_err_ff, brk_ff;
  logic new_frame_ff, mp_bit_ff, addr_seen_ff;
  logic hold_empty_ff, tx_idle_ff;
  uart_regs_pkg::frame_state_t rx_state_ff, tx_state_ff;
  logic [9:0] rx_cnt_ff, tx_cnt_ff;
  logic [2:0] rx_idx_ff, tx_idx_ff;
  logic [7:0] rx_shift_ff, tx_shift_ff;
  logic rx_ninth_ff, tx_ninth_ff;
  logic tx_out_ff;
  logic accept, data_sel, wr_data_acc, rd_data_acc;
  logic buf_ready, buf_valid, tx_pop, tx_first_done;
  logic [7:0] buf_data;
  logic ninth_on, rx_done, rx_perr, rx_brk;
  logic [7:0] stat0, stat1, rd_value;

  assign readdata_o = readdata_ff;
  assign waitrequest_o = wait_ff;
  assign serial_out_pin_o = tx_out_ff;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // full buffer stalls a data write instead of dropping it
  assign data_sel = (address_i[13:2] == uart_regs_pkg::IDX_DATA);
  assign accept = wait_ff && (read_i || write_i)
    && !(write_i && data_sel && byteenable_i[0] && !buf_ready);
  assign wr_data_acc = accept && write_i && data_sel && byteenable_i[0];
  assign rd_data_acc = accept && read_i && data_sel;

  assign stat0 = {avail_ff, par_err_ff, oe_ff, frm_err_ff, brk_ff,
                  hold_empty_ff, tx_idle_ff, cts_ff};
  assign stat1 = {6'h00, new_frame_ff, mp_bit_ff};

  always_comb begin
    unique case (address_i[13:2])
      uart_regs_pkg::IDX_DATA: rd_value = rx_hold_ff;
      uart_regs_pkg::IDX_STAT0: rd_value = stat0;
      uart_regs_pkg::IDX_STAT1: rd_value = stat1;
      uart_regs_pkg::IDX_CTRL: rd_value = {4'h0, ctrl_ff};
      default: rd_value = 8'h00;
    endcase
  end

  // answer one cycle after accept; wait_ff low for exactly one cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_ff <= 1'b1;
      readdata_ff <= 32'h0000_0000;
    end else if (accept) begin
      wait_ff <= 1'b0;
      readdata_ff <= read_i ? {24'h00_0000, rd_value} : 32'h0000_0000;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  // status registers have no write path at all
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_ff <= uart_regs_pkg::CTRL_RST;
    end else if (accept && write_i && byteenable_i[0]
                 && address_i[13:2] == uart_regs_pkg::IDX_CTRL) begin
      ctrl_ff <= writedata_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    cts_ff <= cts_n_i;
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  byte_buffer2 #(
    .WIDTH(8)
  ) u_tx_buf (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(wr_data_acc),
    .in_data_i(writedata_i[7:0]),
    .in_ready_o(buf_ready),
    .out_valid_o(buf_valid),
    .out_ready_i(tx_pop),
    .out_data_o(buf_data)
  );

  assign tx_pop = buf_valid && (tx_state_ff == uart_regs_pkg::FR_IDLE)
    && !(ctrl_ff[uart_regs_pkg::CT_CTS_EN] && cts_ff);
  assign tx_first_done = (tx_state_ff == uart_regs_pkg::FR_START)
    && (tx_cnt_ff == 10'h000);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_state_ff <= uart_regs_pkg::FR_IDLE;
      tx_cnt_ff <= 10'h000;
      tx_idx_ff <= 3'h0;
      tx_shift_ff <= 8'h00;
      tx_ninth_ff <= 1'b0;
      tx_out_ff <= 1'b1;
    end else begin
      tx_cnt_ff <= (tx_cnt_ff == 10'h000) ? 10'h000 : tx_cnt_ff - 10'h001;
      unique case (tx_state_ff)
        uart_regs_pkg::FR_IDLE: begin
          if (tx_pop) begin
            tx_state_ff <= uart_regs_pkg::FR_START;
            tx_shift_ff <= buf_data;
            tx_ninth_ff <= (^buf_data) ^ ctrl_ff[uart_regs_pkg::CT_PAR_ODD];
            tx_out_ff <= 1'b0;
            tx_cnt_ff <= uart_regs_pkg::BIT_CYCLES - 10'h001;
          end
        end
        uart_regs_pkg::FR_START: begin
          if (tx_cnt_ff == 10'h000) begin
            tx_state_ff <= uart_regs_pkg::FR_DATA;
            tx_out_ff <= tx_shift_ff[0];
            tx_idx_ff <= 3'h0;
            tx_cnt_ff <= uart_regs_pkg::BIT_CYCLES - 10'h001;
          end
        end
        uart_regs_pkg::FR_DATA: begin
          if (tx_cnt_ff == 10'h000) begin
            tx_cnt_ff <= uart_regs_pkg::BIT_CYCLES - 10'h001;
            tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
            tx_idx_ff <= tx_idx_ff + 3'h1;
            if (tx_idx_ff != 3'h7) begin
              tx_out_ff <= tx_shift_ff[1];
            end else if (ctrl_ff[uart_regs_pkg::CT_PAR_EN]) begin
              tx_state_ff <= uart_regs_pkg::FR_NINTH;
              tx_out_ff <= tx_ninth_ff;
            end else begin
              tx_state_ff <= uart_regs_pkg::FR_STOP;
              tx_out_ff <= 1'b1;
            end
          end
        end
        uart_regs_pkg::FR_NINTH: begin
          if (tx_cnt_ff == 10'h000) begin
            tx_state_ff <= uart_regs_pkg::FR_STOP;
            tx_out_ff <= 1'b1;
            tx_cnt_ff <= uart_regs_pkg::BIT_CYCLES - 10'h001;
          end
        end
        uart_regs_pkg::FR_STOP: begin
          if (tx_cnt_ff == 10'h000) begin
            tx_state_ff <= uart_regs_pkg::FR_IDLE;
          end
        end
        default: begin
          tx_state_ff <= uart_regs_pkg::FR_IDLE;
          tx_out_ff <= 1'b1;
        end
      endcase
    end
  end

  // set after the start bit wins over a same-cycle write
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_empty_ff <= uart_regs_pkg::HOLD_EMPTY_RST;
      tx_idle_ff <= uart_regs_pkg::TX_IDLE_RST;
    end else begin
      if (tx_first_done) begin
        hold_empty_ff <= 1'b1;
      end else if (wr_data_acc) begin
        hold_empty_ff <= 1'b0;
      end
      tx_idle_ff <= (tx_state_ff == uart_regs_pkg::FR_IDLE)
        && !buf_valid;
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  // in multiprocessor mode the ninth slot carries the address bit
  assign ninth_on = ctrl_ff[uart_regs_pkg::CT_PAR_EN]
    || ctrl_ff[uart_regs_pkg::CT_MP_EN];
  assign rx_done = (rx_state_ff == uart_regs_pkg::FR_STOP)
    && (rx_cnt_ff == 10'h000);
  assign rx_perr = ctrl_ff[uart_regs_pkg::CT_PAR_EN]
    && !ctrl_ff[uart_regs_pkg::CT_MP_EN]
    && (rx_ninth_ff != ((^rx_shift_ff) ^ ctrl_ff[uart_regs_pkg::CT_PAR_ODD]));
  assign rx_brk = (rx_shift_ff == 8'h00) && !rx_ninth_ff
    && !serial_in_pin_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_state_ff <= uart_regs_pkg::FR_IDLE;
      rx_cnt_ff <= 10'h000;
      rx_idx_ff <= 3'h0;
      rx_shift_ff <= 8'h00;
      rx_ninth_ff <= 1'b0;
    end else begin
      rx_cnt_ff <= (rx_cnt_ff == 10'h000) ? 10'h000 : rx_cnt_ff - 10'h001;
      unique case (rx_state_ff)
        uart_regs_pkg::FR_IDLE: begin
          if (!serial_in_pin_i) begin
            rx_state_ff <= uart_regs_pkg::FR_START;
            rx_cnt_ff <= uart_regs_pkg::HALF_CYCLES - 10'h001;
          end
        end
        uart_regs_pkg::FR_START: begin
          if (rx_cnt_ff == 10'h000) begin
            rx_state_ff <= serial_in_pin_i ? uart_regs_pkg::FR_IDLE
                                           : uart_regs_pkg::FR_DATA;
            rx_idx_ff <= 3'h0;
            rx_ninth_ff <= 1'b0;
            rx_cnt_ff <= uart_regs_pkg::BIT_CYCLES - 10'h001;
          end
        end
        uart_regs_pkg::FR_DATA: begin
          if (rx_cnt_ff == 10'h000) begin
            rx_shift_ff <= {serial_in_pin_i, rx_shift_ff[7:1]};
            rx_idx_ff <= rx_idx_ff + 3'h1;
            rx_cnt_ff <= uart_regs_pkg::BIT_CYCLES - 10'h001;
            if (rx_idx_ff == 3'h7) begin
              rx_state_ff <= ninth_on ? uart_regs_pkg::FR_NINTH
                                      : uart_regs_pkg::FR_STOP;
            end
          end
        end
        uart_regs_pkg::FR_NINTH: begin
          if (rx_cnt_ff == 10'h000) begin
            rx_ninth_ff <= serial_in_pin_i;
            rx_state_ff <= uart_regs_pkg::FR_STOP;
            rx_cnt_ff <= uart_regs_pkg::BIT_CYCLES - 10'h001;
          end
        end
        uart_regs_pkg::FR_STOP: begin
          if (rx_cnt_ff == 10'h000) begin
            rx_state_ff <= uart_regs_pkg::FR_IDLE;
          end
        end
        default: begin
          rx_state_ff <= uart_regs_pkg::FR_IDLE;
        end
      endcase
    end
  end

  // cleared only so checks never meet an unknown byte;
  // software still treats it as undefined until a byte lands
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_hold_ff <= uart_regs_pkg::RX_HOLD_RST;
    end else if (rx_done && !(avail_ff && !rd_data_acc)) begin
      rx_hold_ff <= rx_shift_ff;
    end
  end

  // a byte arriving with the data read is loaded, not lost
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avail_ff <= 1'b0;
      par_err_ff <= 1'b0;
      oe_ff <= 1'b0;
      frm_err_ff <= 1'b0;
      brk_ff <= 1'b0;
      new_frame_ff <= 1'b0;
      mp_bit_ff <= 1'b0;
      addr_seen_ff <= 1'b0;
    end else begin
      if (rx_done && avail_ff && !rd_data_acc) begin
        oe_ff <= 1'b1;
      end else if (rx_done) begin
        avail_ff <= 1'b1;
        par_err_ff <= rx_perr;
        frm_err_ff <= !serial_in_pin_i;
        brk_ff <= rx_brk;
        if (ctrl_ff[uart_regs_pkg::CT_MP_EN]) begin
          mp_bit_ff <= rx_ninth_ff;
          new_frame_ff <= addr_seen_ff && !rx_ninth_ff;
          addr_seen_ff <= rx_ninth_ff;
        end else begin
          mp_bit_ff <= 1'b0;
          new_frame_ff <= 1'b0;
        end
        if (rd_data_acc && !avail_ff) begin
          oe_ff <= 1'b0;
        end
      end else if (rd_data_acc) begin
        avail_ff <= 1'b0;
        par_err_ff <= 1'b0;
        frm_err_ff <= 1'b0;
        brk_ff <= 1'b0;
        new_frame_ff <= 1'b0;
        mp_bit_ff <= 1'b0;
        if (!avail_ff) begin
          oe_ff <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_tx_start;
    tx_pop |=> !serial_out_pin_o ##1 !serial_out_pin_o;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit");

  property p_write_keeps_rx;
    (wr_data_acc && !rx_done) |=> $stable(rx_hold_ff);
  endproperty
  a_write_keeps_rx: assert property (p_write_keeps_rx)
    else $error("write touched receive data");

  property p_rx_load;
    (rx_done && !avail_ff) |=> avail_ff && rx_hold_ff == $past(rx_shift_ff)
      && par_err_ff == $past(rx_perr) && brk_ff == $past(rx_brk);
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("byte and flags not loaded together");

  property p_avail_clear;
    (rd_data_acc && !rx_done) |=> !avail_ff && !par_err_ff && !frm_err_ff
      && !brk_ff;
  endproperty
  a_avail_clear: assert property (p_avail_clear)
    else $error("data read left flags set");

  property p_overrun;
    (rx_done && avail_ff && !rd_data_acc) |=> oe_ff && $stable(rx_hold_ff);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun lost old byte");

  property p_oe_hold;
    (rd_data_acc && avail_ff && oe_ff) |=> oe_ff;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("overrun cleared while byte pending");

  property p_empty_clear;
    (wr_data_acc && !tx_first_done) |=> !hold_empty_ff;
  endproperty
  a_empty_clear: assert property (p_empty_clear)
    else $error("holding empty not cleared");

  property p_empty_set;
    tx_first_done |=> hold_empty_ff && tx_state_ff == uart_regs_pkg::FR_DATA;
  endproperty
  a_empty_set: assert property (p_empty_set)
    else $error("holding empty not set after start bit");

  property p_idle_busy;
    (tx_state_ff != uart_regs_pkg::FR_IDLE) |=> !tx_idle_ff;
  endproperty
  a_idle_busy: assert property (p_idle_busy)
    else $error("transmitter empty while sending");

  property p_cts;
    ##2 stat0[uart_regs_pkg::ST_CTS] == $past(cts_n_i);
  endproperty
  a_cts: assert property (p_cts)
    else $error("clear-to-send bit stale");

  c_overrun: cover property (rx_done && avail_ff);
  c_tx_frame: cover property (tx_first_done);
  c_rd_data: cover property (rd_data_acc && avail_ff);
  c_break: cover property (rx_done && rx_brk);

endmodule // uart_data_status_regs
`default_nettype wire

// file: uart_regs_pkg.sv
// Purpose: shared constants and types for the serial data/status block
// Assumes: 100 MHz system clock, fixed bit rate
// Notes: register indexes are word indexes; byte address is index * 4
package uart_regs_pkg;

  // ----------------------------------------------------------------
  // register indexes
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_DATA = 12'hF40;
  localparam logic [11:0] IDX_STAT0 = 12'hF41;
  localparam logic [11:0] IDX_STAT1 = 12'hF44;
  localparam logic [11:0] IDX_CTRL = 12'hF48;

  // ----------------------------------------------------------------
  // status 0 / status 1 / control fields
  // ----------------------------------------------------------------
  localparam int ST_AVAIL = 7;
  localparam int ST_PAR_ERR = 6;
  localparam int ST_OE = 5;
  localparam int ST_FRM_ERR = 4;
  localparam int ST_BRK = 3;
  localparam int ST_HOLD_EMPTY = 2;
  localparam int ST_TX_IDLE = 1;
  localparam int ST_CTS = 0;
  localparam int S1_NEW_FRAME = 1;
  localparam int S1_MP_BIT = 0;
  localparam int CT_PAR_EN = 0;
  localparam int CT_PAR_ODD = 1;
  localparam int CT_MP_EN = 2;
  localparam int CT_CTS_EN = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic HOLD_EMPTY_RST = 1'b1;
  localparam logic TX_IDLE_RST = 1'b1;
  localparam logic [7:0] RX_HOLD_RST = 8'h00;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS = 8680;
  localparam logic [9:0] BIT_CYCLES = 10'(BIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [9:0] HALF_CYCLES = 10'(BIT_TIME_NS / CLK_PERIOD_NS / 2);

  // ----------------------------------------------------------------
  // frame state machines
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    FR_IDLE = 5'h01,
    FR_START = 5'h02,
    FR_DATA = 5'h04,
    FR_NINTH = 5'h08,
    FR_STOP = 5'h10
  } frame_state_t;

endpackage

// file: byte_buffer2.sv
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-high reset
// Notes: in_ready_o drops only when both entries hold data
`timescale 1ns/1ps
`default_nettype none
module byte_buffer2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign in_ready_o = (count_ff != 2'h2);
  assign out_valid_o = (count_ff != 2'h0);
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end

endmodule // byte_buffer2
`default_nettype wire

// file: uart_remote_model.sv
// Purpose: remote serial device facing the data/status block
// Assumes: start bit, 8 data bits lsb first, optional ninth, one stop
// Notes: line idles high between frames, so no stale level lingers
`timescale 1ns/1ps
`default_nettype none
module uart_remote_model (
  // clock
  input wire logic clk_i,
  // link
  output logic line_o,
  input wire logic line_i,
  // captured byte
  output logic got_o,
  output logic [7:0] byte_o
);
  localparam int BITC = int'(uart_regs_pkg::BIT_CYCLES);
  localparam int HALFC = int'(uart_regs_pkg::HALF_CYCLES);
  logic [7:0] sh;
  int i;

  task automatic send(input logic [7:0] d, input logic n_en,
                      input logic n, input logic stp);
    int k;
    line_o <= 1'b0;
    repeat (BITC) @(posedge clk_i);
    for (k = 0; k < 8; k++) begin
      line_o <= d[k];
      repeat (BITC) @(posedge clk_i);
    end
    if (n_en) begin
      line_o <= n;
      repeat (BITC) @(posedge clk_i);
    end
    line_o <= stp;
    repeat (BITC) @(posedge clk_i);
    line_o <= 1'b1;
    // one idle cycle: a following frame never reassigns the line in-step
    @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // receiver: mid-bit sampling of the block's transmit line
  // ----------------------------------------------------------------
  initial begin
    line_o = 1'b1;
    got_o = 1'b0;
    byte_o = 8'h00;
    forever begin
      @(negedge line_i);
      repeat (HALFC) @(posedge clk_i);
      for (i = 0; i < 8; i++) begin
        repeat (BITC) @(posedge clk_i);
        sh[i] = line_i;
      end
      repeat (BITC) @(posedge clk_i);
      byte_o <= sh;
      got_o <= 1'b1;
      @(posedge clk_i);
      got_o <= 1'b0;
    end
  end
endmodule // uart_remote_model
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench for the data/status registers
// Assumes: avalon-mm master tasks, remote model on the link
// Notes: reads note expectations in a queue, a monitor compares
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [13:0] A_DAT = {uart_regs_pkg::IDX_DATA, 2'b00};
  localparam logic [13:0] A_ST0 = {uart_regs_pkg::IDX_STAT0, 2'b00};
  localparam logic [13:0] A_ST1 = {uart_regs_pkg::IDX_STAT1, 2'b00};
  localparam logic [13:0] A_CTL = {uart_regs_pkg::IDX_CTRL, 2'b00};
  localparam int LIMIT = 95000;
  logic clk_i, sys_rst_i, read_i, write_i, cts_n_i, rx_line, got;
  logic [13:0] address_i;
  logic [3:0] byteenable_i;
  logic [31:0] writedata_i, readdata_o, q, e, m;
  logic waitrequest_o, serial_out_pin_o;
  logic [7:0] rx_byte, a, b, t_exp;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0] tx_q[$];
  int fail_count, compares, cycles;

  uart_data_status_regs uart_data_status_regs_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .byteenable_i(byteenable_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .serial_in_pin_i(rx_line),
    .serial_out_pin_o(serial_out_pin_o), .cts_n_i(cts_n_i));
  uart_remote_model uart_remote_model_i (.clk_i(clk_i), .line_o(rx_line),
    .line_i(serial_out_pin_o), .got_o(got), .byte_o(rx_byte));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    compares++;
    if (got_v !== exp_v) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && compares > 0 && tx_q.size() == 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus master tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [13:0] ad, input logic [7:0] d);
    address_i <= ad;
    writedata_i <= {24'h000000, d};
    write_i <= 1'b1;
    @(posedge clk_i);
    while (waitrequest_o !== 1'b0) @(posedge clk_i);
    write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // mask of zero means a poll: answer taken but not compared
  task automatic rd(input logic [13:0] ad, input logic [31:0] ev,
                    input logic [31:0] mv);
    exp_q.push_back(ev);
    msk_q.push_back(mv);
    address_i <= ad;
    read_i <= 1'b1;
    @(posedge clk_i);
    while (waitrequest_o !== 1'b0) @(posedge clk_i);
    q = readdata_o;
    read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic poll(input int bn, input logic v);
    q = ~32'h0;
    q[bn] = ~v;
    while (q[bn] !== v) rd(A_ST0, 32'h0, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // monitor: oldest note against each result
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (read_i === 1'b1 && waitrequest_o === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0) chk(readdata_o & m, e & m);
    end
    if (got === 1'b1) begin
      t_exp = (tx_q.size() > 0) ? tx_q.pop_front() : ~rx_byte;
      chk({24'h0, rx_byte}, {24'h0, t_exp});
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    fail_count = 0;
    compares = 0;
    cycles = 0;
    sys_rst_i = 1'b1;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = 14'h0000;
    byteenable_i = 4'hF;
    writedata_i = 32'h0;
    cts_n_i = 1'b1;
    void'($urandom(65682));
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(A_ST0, 32'h06, 32'hFFFFFFFE);
    wr(A_ST0, 8'hF9);
    rd(A_ST0, 32'h06, 32'hFFFFFFFE);
    rd(14'h3E00, 32'h0, 32'hFFFFFFFF);
    for (int v = 0; v < 2; v++) begin
      cts_n_i <= v[0];
      repeat (3) @(posedge clk_i);
      rd(A_ST0, {31'h0, v[0]}, 32'h1);
    end
    // transmit two bytes, second only once holding is empty again
    a = 8'($urandom);
    b = 8'($urandom);
    tx_q.push_back(a);
    tx_q.push_back(b);
    wr(A_DAT, a);
    rd(A_ST0, 32'h0, 32'h06);
    poll(uart_regs_pkg::ST_HOLD_EMPTY, 1'b1);
    wr(A_DAT, b);
    rd(A_ST0, 32'h0, 32'h04);
    poll(uart_regs_pkg::ST_TX_IDLE, 1'b1);
    // plain receive
    a = 8'($urandom);
    uart_remote_model_i.send(a, 1'b0, 1'b0, 1'b1);
    rd(A_ST0, 32'h86, 32'hFE);
    rd(A_DAT, {24'h0, a}, 32'hFFFFFFFF);
    rd(A_ST0, 32'h06, 32'hFE);
    // overrun: second byte meets unread first
    a = 8'($urandom);
    b = ~a;
    uart_remote_model_i.send(a, 1'b0, 1'b0, 1'b1);
    uart_remote_model_i.send(b, 1'b0, 1'b0, 1'b1);
    rd(A_ST0, 32'hA6, 32'hFE);
    rd(A_DAT, {24'h0, a}, 32'hFF);
    rd(A_ST0, 32'h26, 32'hFE);
    rd(A_DAT, 32'h0, 32'h0);
    rd(A_ST0, 32'h06, 32'hFE);
    // odd parity on, wrong ninth bit
    wr(A_CTL, 8'h03);
    rd(A_CTL, 32'h03, 32'hFF);
    a = 8'($urandom);
    uart_remote_model_i.send(a, 1'b1, ^a, 1'b1);
    rd(A_ST0, 32'hC6, 32'hFE);
    rd(A_DAT, {24'h0, a}, 32'hFF);
    rd(A_ST0, 32'h06, 32'hFE);
    rd(A_ST1, 32'h0, 32'hFF);
    // all-zero frame under even parity: break with framing error
    wr(A_CTL, 8'h01);
    uart_remote_model_i.send(8'h00, 1'b1, 1'b0, 1'b0);
    rd(A_ST0, 32'h9E, 32'hFE);
    rd(A_DAT, 32'h0, 32'hFF);
    rd(A_ST0, 32'h06, 32'hFE);
    // multiprocessor: address byte, then first data byte of a frame
    wr(A_CTL, 8'h04);
    a = 8'($urandom);
    b = 8'($urandom);
    uart_remote_model_i.send(a, 1'b1, 1'b1, 1'b1);
    rd(A_ST1, 32'h01, 32'hFF);
    rd(A_DAT, {24'h0, a}, 32'hFF);
    rd(A_ST1, 32'h00, 32'hFF);
    uart_remote_model_i.send(b, 1'b1, 1'b0, 1'b1);
    rd(A_ST1, 32'h02, 32'hFF);
    rd(A_DAT, {24'h0, b}, 32'hFF);
    rd(A_ST1, 32'h00, 32'hFF);
    repeat (5) @(posedge clk_i);
    conclude();
  end
endmodule // tb
`default_nettype wire
